// file: hdl/ibr_bitrate.sv
// Bit-rate generator, own-address match and register bank behind an AHB-Lite slave
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps

// Functional notes
// - Fastest bit rate is bus clock over twenty
// - Same behaviour in normal, special, emulation modes
// - Wait mode optionally gates bit clock, halting transfer
// - Stop mode inactive; registers keep their values
// - Five registers at consecutive offsets, always accessible; this block maps nine: adds generator control and three timing readouts
// - Own address in bits 7-1, resets zero
// - Own address used only for matching
// - Own address bit 0 always reads zero
// - Default slave, responds on address match
// - Rate code: multiplier, prescaler, tap fields
// - Tap code gives clock and data tap
// - Data tap sets SDA hold after SCL fall
// - Prescaler code gives offsets and spacing
// - First tap offset, then spacing two-power-code
// - Multiplier codes give factors 1, 2, 4
// - SCL period from multiplier, offset, tap, spacing
// - SDA hold lasts hold count bus clocks
// - SDA hold count formula with plus three
// - Start and stop SCL hold counts
module ibr_bitrate
    import ibr_pkg::*;
(
    input  wire logic              clk_i,          // Bus clock, 10 MHz
    input  wire logic              rstn_i,         // Asynchronous reset, active low
    input  wire logic              hsel_i,         // AHB slave select
    input  wire logic [31:0]       haddr_i,        // AHB address
    input  wire logic [1:0]        htrans_i,       // AHB transfer type
    input  wire logic              hwrite_i,       // AHB write
    input  wire logic [2:0]        hsize_i,        // AHB size
    input  wire logic [31:0]       hwdata_i,       // AHB write data
    input  wire logic              hready_i,       // AHB bus ready
    output logic [31:0]            hrdata_o,       // AHB read data
    output logic                   hreadyout_o,    // AHB slave ready
    output logic [1:0]             hresp_o,        // AHB response
    input  wire logic              wait_mode_i,    // CPU in wait mode
    input  wire logic              stop_mode_i,    // CPU in stop mode
    input  wire logic              tx_bit_i,       // Next bit to put on SDA
    input  wire logic [6:0]        rx_addr_i,      // Received calling address
    input  wire logic              rx_addr_vld_i,  // Received address valid pulse
    output logic                   addr_match_o,   // Calling address hit, one pulse
    output logic                   sda_shift_o,    // SDA hold point reached, one pulse
    output ibr_timing_t            timing_o,       // Decoded timing counts
    input  wire logic              scl_i,          // SCL pin level
    output logic                   scl_o,          // SCL output level, always low
    output logic                   scl_oe_o,       // SCL pull-down enable
    input  wire logic              sda_i,          // SDA pin level
    output logic                   sda_o,          // SDA output level, always low
    output logic                   sda_oe_o        // SDA pull-down enable
);

    // Multiplier factor; reserved code treated as the largest factor
    function automatic logic [CW-1:0] mul_factor(input logic [1:0] code);
        logic [CW-1:0] f;
        f = CW'(1) << code;
        if (code == 2'h3) begin
            f = CW'(4);
        end
        return f;
    endfunction : mul_factor

    // Offset plus (tap - 1) spacings; spacing is two to the prescaler code
    function automatic logic [CW-1:0] tap_count(input logic [7:0] ofs,
                                                input logic [7:0] tap,
                                                input logic [2:0] pre);
        return CW'(ofs) + ((CW'(tap) - CW'(1)) << pre);
    endfunction : tap_count

    logic [DW-1:0]         own_addr_q;
    logic [DW-1:0]         rate_div_q;
    logic [DW-1:0]         bus_ctrl_q;
    logic [DW-1:0]         bus_stat_q;
    logic [DW-1:0]         bus_data_q;
    logic [DW-1:0]         gen_ctrl_q;
    ibr_timing_t           timing_q;
    logic                  wr_pend_q;
    logic [IDX_W-1:0]      wr_idx_q;
    logic [31:0]           hrdata_q;
    logic                  hready_q;
    ibr_gen_state_t        state_q;
    logic [CW-1:0]         cnt_q;
    logic [CW-1:0]         hold_cnt_q;
    logic                  hold_run_q;
    logic                  scl_oe_q;
    logic                  sda_oe_q;
    logic                  sda_shift_q;
    logic                  match_q;

    // Rate code decode
    wire logic [1:0]       mul_code  = rate_div_q[MUL_LSB +: 2];
    wire logic [2:0]       pre_code  = rate_div_q[PRE_LSB +: 3];
    wire logic [2:0]       tap_code  = rate_div_q[TAP_LSB +: 3];
    wire logic [CW-1:0]    mul       = mul_factor(mul_code);
    wire logic [7:0]       scl_tap   = SCL_TAP_LUT[tap_code];
    wire logic [7:0]       sda_tap   = SDA_TAP_LUT[tap_code];
    wire logic [7:0]       first_ofs = FIRST_TAP_LUT[pre_code];
    wire logic [7:0]       start_ofs = START_OFS_LUT[pre_code];
    wire logic [7:0]       stop_ofs  = STOP_OFS_LUT[pre_code];
    wire logic [CW-1:0]    scl_sum   = tap_count(first_ofs, scl_tap, pre_code);
    wire logic [CW-1:0]    sda_sum   = tap_count(first_ofs, sda_tap, pre_code);
    wire logic [CW-1:0]    div_raw   = CW'(mul * ((scl_sum + SCL_DIV_PAD) << 1));
    wire logic [CW-1:0]    div_lim   = (div_raw < MIN_SCL_DIV) ? MIN_SCL_DIV : div_raw;
    wire logic [CW-1:0]    sda_cnt   = CW'(mul * (sda_sum + SDA_PAD));
    wire logic [CW-1:0]    start_cnt = CW'(mul * tap_count(start_ofs, scl_tap, pre_code));
    wire logic [CW-1:0]    stop_cnt  = CW'(mul * tap_count(stop_ofs, scl_tap, pre_code));
    wire ibr_timing_t      timing_d  = '{scl_div: div_lim, sda_hold: sda_cnt,
                                         start_hold: start_cnt, stop_hold: stop_cnt};

    // AHB decode
    wire logic             addr_ph   = hsel_i && hready_i &&
                                       (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
    wire logic [IDX_W-1:0] idx       = haddr_i[IDX_LSB +: IDX_W];
    wire logic             wr_now    = wr_pend_q;
    wire logic [DW-1:0]    wbyte     = hwdata_i[DW-1:0];
    wire logic             wr_own    = wr_now && wr_idx_q == IDX_OWN_ADDR;
    wire logic             wr_rate   = wr_now && wr_idx_q == IDX_RATE_DIV;
    wire logic             wr_ctrl   = wr_now && wr_idx_q == IDX_BUS_CTRL;
    wire logic             wr_stat   = wr_now && wr_idx_q == IDX_BUS_STAT;
    wire logic             wr_data   = wr_now && wr_idx_q == IDX_BUS_DATA;
    wire logic             wr_gen    = wr_now && wr_idx_q == IDX_GEN_CTRL;

    // Read value, with a write still in its data phase forwarded
    wire logic [DW-1:0]    own_rd    = (wr_own ? wbyte : own_addr_q) & OWN_ADDR_MASK;
    wire logic [DW-1:0]    rate_rd   = wr_rate ? wbyte : rate_div_q;
    wire logic [DW-1:0]    ctrl_rd   = wr_ctrl ? wbyte : bus_ctrl_q;
    wire logic [DW-1:0]    stat_rd   = wr_stat ? wbyte : bus_stat_q;
    wire logic [DW-1:0]    data_rd   = wr_data ? wbyte : bus_data_q;
    wire logic [DW-1:0]    gen_rd    = (wr_gen ? wbyte : gen_ctrl_q) & GEN_CTRL_MASK;
    logic [31:0]           rd_val;

    always_comb begin
        unique case (idx)
            IDX_OWN_ADDR: rd_val = {24'h000000, own_rd};
            IDX_RATE_DIV: rd_val = {24'h000000, rate_rd};
            IDX_BUS_CTRL: rd_val = {24'h000000, ctrl_rd};
            IDX_BUS_STAT: rd_val = {24'h000000, stat_rd};
            IDX_BUS_DATA: rd_val = {24'h000000, data_rd};
            IDX_GEN_CTRL: rd_val = {24'h000000, gen_rd};
            IDX_SCL_DIV:  rd_val = {16'h0000, timing_q.scl_div};
            IDX_SDA_HOLD: rd_val = {16'h0000, timing_q.sda_hold};
            IDX_SS_HOLD:  rd_val = {timing_q.stop_hold, timing_q.start_hold};
            default:      rd_val = 32'h00000000;
        endcase
    end

    // Registers take writes in stop mode too and never reset on mode entry
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= '0;
            hrdata_q  <= 32'h00000000;
            hready_q  <= 1'b1;
        end else begin
            wr_pend_q <= addr_ph && hwrite_i;
            wr_idx_q  <= idx;
            hready_q  <= 1'b1;
            if (addr_ph && !hwrite_i) begin
                hrdata_q <= rd_val;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            own_addr_q <= OWN_ADDR_RST;
            rate_div_q <= RATE_DIV_RST;
            bus_ctrl_q <= BYTE_RST;
            bus_stat_q <= BYTE_RST;
            bus_data_q <= BYTE_RST;
            gen_ctrl_q <= BYTE_RST;
        end else begin
            if (wr_own) begin
                own_addr_q <= wbyte & OWN_ADDR_MASK;
            end
            if (wr_rate) begin
                rate_div_q <= wbyte;
            end
            if (wr_ctrl) begin
                bus_ctrl_q <= wbyte;
            end
            if (wr_stat) begin
                bus_stat_q <= wbyte;
            end
            if (wr_data) begin
                bus_data_q <= wbyte;
            end
            if (wr_gen) begin
                gen_ctrl_q <= wbyte & GEN_CTRL_MASK;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timing_q <= '0;
        end else begin
            timing_q <= timing_d;
        end
    end

    // Slave match is only compared against the received address
    wire logic             addr_hit  = rx_addr_vld_i &&
                                       rx_addr_i == own_addr_q[DW-1:1];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= addr_hit && !stop_mode_i;
        end
    end

    // Generator runs only when enabled and not halted by a low-power mode
    wire logic             wait_halt = wait_mode_i && gen_ctrl_q[WAIT_GATE_BIT];
    wire logic             halt      = stop_mode_i || wait_halt;
    wire logic             gen_run   = gen_ctrl_q[GEN_EN_BIT] && !halt;
    wire logic [CW-1:0]    half_div  = timing_q.scl_div >> 1;
    wire logic             half_done = cnt_q >= half_div - CW'(1);
    wire logic             hold_done = hold_cnt_q >= timing_q.sda_hold;

    ibr_gen_state_t        state_d;
    logic [CW-1:0]         cnt_d;

    // Next phase of SCL; a halt drops back to idle at once
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (!gen_run) begin
            state_d = GEN_IDLE;
            cnt_d   = '0;
        end else begin
            unique case (state_q)
                GEN_IDLE: begin
                    state_d = GEN_LOW;
                    cnt_d   = '0;
                end
                GEN_LOW: begin
                    if (half_done) begin
                        state_d = GEN_HIGH;
                        cnt_d   = '0;
                    end else begin
                        cnt_d = cnt_q + CW'(1);
                    end
                end
                GEN_HIGH: begin
                    if (half_done) begin
                        state_d = GEN_LOW;
                        cnt_d   = '0;
                    end else if (scl_i) begin
                        cnt_d = cnt_q + CW'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= GEN_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // SDA hold timer restarts at each SCL falling edge the block makes
    wire logic             scl_fall  = gen_run && state_q != GEN_LOW &&
                                       (state_q == GEN_IDLE || half_done);

    logic                  hold_run_d;
    logic [CW-1:0]         hold_cnt_d;
    logic                  sda_shift_d;
    logic                  sda_oe_d;

    // SDA moves when the hold count has run out after the fall
    always_comb begin
        hold_run_d  = hold_run_q;
        hold_cnt_d  = hold_cnt_q;
        sda_shift_d = 1'b0;
        sda_oe_d    = sda_oe_q;
        if (!gen_run) begin
            hold_run_d = 1'b0;
            hold_cnt_d = '0;
            sda_oe_d   = 1'b0;
        end else if (scl_fall) begin
            hold_run_d = 1'b1;
            hold_cnt_d = CW'(1);
        end else if (hold_run_q) begin
            if (hold_done) begin
                hold_run_d  = 1'b0;
                sda_shift_d = 1'b1;
                sda_oe_d    = !tx_bit_i;
            end else begin
                hold_cnt_d = hold_cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_run_q  <= 1'b0;
            hold_cnt_q  <= '0;
            sda_shift_q <= 1'b0;
            sda_oe_q    <= 1'b0;
        end else begin
            hold_run_q  <= hold_run_d;
            hold_cnt_q  <= hold_cnt_d;
            sda_shift_q <= sda_shift_d;
            sda_oe_q    <= sda_oe_d;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_oe_q <= 1'b0;
        end else begin
            scl_oe_q <= gen_run && (scl_fall || (state_q == GEN_LOW && !half_done));
        end
    end

    assign hrdata_o     = hrdata_q;
    assign hreadyout_o  = hready_q;
    assign hresp_o      = HRESP_OKAY;
    assign addr_match_o = match_q;
    assign sda_shift_o  = sda_shift_q;
    assign timing_o     = timing_q;
    assign scl_o        = 1'b0;
    assign sda_o        = 1'b0;
    assign scl_oe_o     = scl_oe_q;
    assign sda_oe_o     = sda_oe_q;

endmodule : ibr_bitrate

// file: hdl/ibr_pkg.sv
// Package: register map, decode tables and carrier types of the bit-rate block
package ibr_pkg;

    localparam int          DW          = 8;
    localparam int          CW          = 16;
    localparam int          IDX_W       = 6;
    localparam int          IDX_LSB     = 2;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_OWN_ADDR  = 6'h00;
    localparam logic [IDX_W-1:0] IDX_RATE_DIV  = 6'h01;
    localparam logic [IDX_W-1:0] IDX_BUS_CTRL  = 6'h02;
    localparam logic [IDX_W-1:0] IDX_BUS_STAT  = 6'h03;
    localparam logic [IDX_W-1:0] IDX_BUS_DATA  = 6'h04;
    localparam logic [IDX_W-1:0] IDX_GEN_CTRL  = 6'h05;
    localparam logic [IDX_W-1:0] IDX_SCL_DIV   = 6'h06;
    localparam logic [IDX_W-1:0] IDX_SDA_HOLD  = 6'h07;
    localparam logic [IDX_W-1:0] IDX_SS_HOLD   = 6'h08;

    localparam logic [DW-1:0] OWN_ADDR_RST  = 8'h00;
    localparam logic [DW-1:0] RATE_DIV_RST  = 8'h00;
    localparam logic [DW-1:0] BYTE_RST      = 8'h00;
    localparam logic [DW-1:0] OWN_ADDR_MASK = 8'hFE;
    localparam logic [DW-1:0] GEN_CTRL_MASK = 8'h03;

    // Generator control fields
    localparam int GEN_EN_BIT      = 0;
    localparam int WAIT_GATE_BIT   = 1;

    // Rate code fields
    localparam int MUL_LSB = 6;
    localparam int PRE_LSB = 3;
    localparam int TAP_LSB = 0;

    localparam logic [CW-1:0] MIN_SCL_DIV = 16'h0014;
    localparam logic [CW-1:0] SCL_DIV_PAD = 16'h0002;
    localparam logic [CW-1:0] SDA_PAD     = 16'h0003;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
    localparam logic [1:0]  HRESP_OKAY    = 2'h0;

    typedef logic [7:0] ibr_lut8_t [8];

    localparam ibr_lut8_t SCL_TAP_LUT   = '{8'h05, 8'h06, 8'h07, 8'h08,
                                            8'h09, 8'h0A, 8'h0C, 8'h0F};
    localparam ibr_lut8_t SDA_TAP_LUT   = '{8'h01, 8'h01, 8'h02, 8'h02,
                                            8'h03, 8'h03, 8'h04, 8'h04};
    localparam ibr_lut8_t START_OFS_LUT = '{8'h02, 8'h02, 8'h02, 8'h06,
                                            8'h0E, 8'h1E, 8'h3E, 8'h7E};
    localparam ibr_lut8_t STOP_OFS_LUT  = '{8'h07, 8'h07, 8'h09, 8'h09,
                                            8'h11, 8'h21, 8'h41, 8'h81};
    localparam ibr_lut8_t FIRST_TAP_LUT = '{8'h04, 8'h04, 8'h06, 8'h06,
                                            8'h0E, 8'h1E, 8'h3E, 8'h7E};

    typedef struct packed {
        logic [CW-1:0] scl_div;
        logic [CW-1:0] sda_hold;
        logic [CW-1:0] start_hold;
        logic [CW-1:0] stop_hold;
    } ibr_timing_t;

    typedef enum logic [1:0] {
        GEN_IDLE,
        GEN_LOW,
        GEN_HIGH
    } ibr_gen_state_t;

endpackage : ibr_pkg

// file: sim/ibr_bitrate_assertions.sv
// Checker: port-level properties of the bit-rate block
`timescale 1ns/1ps
module ibr_bitrate_checker
    import ibr_pkg::*;
(
    input wire logic        clk_i,         // Bus clock
    input wire logic        rstn_i,        // Reset, active low
    input wire logic        rx_addr_vld_i, // Address valid pulse
    input wire logic        stop_mode_i,   // Stop mode
    input wire logic        hreadyout_o,   // Slave ready
    input wire logic [1:0]  hresp_o,       // Response code
    input wire logic        addr_match_o,  // Match pulse
    input wire logic        sda_shift_o,   // Hold point pulse
    input wire ibr_timing_t timing_o,      // Decoded counts
    input wire logic        scl_o,         // SCL level
    input wire logic        scl_oe_o,      // SCL pull-down
    input wire logic        sda_o,         // SDA level
    input wire logic        sda_oe_o       // SDA pull-down
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_bus_ready_okay: assert property (hreadyout_o && hresp_o == HRESP_OKAY)
        else $error("bus slave not ready or response not OKAY");
    a_scl_div_floor: assert property ($past(rstn_i) |-> timing_o.scl_div >= MIN_SCL_DIV)
        else $error("clock divider below twenty");
    a_sda_in_low: assert property ($past(rstn_i) |->
        timing_o.sda_hold < (timing_o.scl_div >> 1))
        else $error("data hold not inside clock low phase");
    a_stop_after_start: assert property ($past(rstn_i) |->
        timing_o.stop_hold > timing_o.start_hold)
        else $error("stop hold not above start hold");
    a_match_cause: assert property (addr_match_o |->
        $past(rx_addr_vld_i) && !$past(stop_mode_i))
        else $error("address match without a valid address");
    a_pins_drive_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin driven high");
    a_stop_halts: assert property (stop_mode_i |=> !scl_oe_o && !sda_oe_o)
        else $error("pins still pulled in stop mode");
    a_shift_in_low: assert property (sda_shift_o |-> scl_oe_o)
        else $error("data hold point outside clock low phase");
endmodule : ibr_bitrate_checker

bind ibr_bitrate ibr_bitrate_checker ibr_bitrate_checker_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .rx_addr_vld_i(rx_addr_vld_i), .stop_mode_i(stop_mode_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .addr_match_o(addr_match_o),
    .sda_shift_o(sda_shift_o), .timing_o(timing_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o)
);

// file: sim/ibr_bitrate_tb.sv
// Testbench: register bank, rate decode, address match and bit generator
`timescale 1ns/1ps
module ibr_bitrate_tb
    import ibr_pkg::*;
;
    logic        clk, rstn, hsel, hwrite, wait_m, stop_m, tx_bit, rx_vld, hready;
    logic        match, shift, scl, sda, scl_out, scl_oe, sda_out, sda_oe;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, hresp;
    logic [6:0]  rx_addr;
    logic [7:0]  stretch;
    ibr_timing_t timing;
    int          n_mismatch, n_compared, n;
    int          sct[8] = '{5, 6, 7, 8, 9, 10, 12, 15};
    int          sdt[8] = '{1, 1, 2, 2, 3, 3, 4, 4};
    int          sto[8] = '{2, 2, 2, 6, 14, 30, 62, 126};
    int          spo[8] = '{7, 7, 9, 9, 17, 33, 65, 129};
    int          ft[8]  = '{4, 4, 6, 6, 14, 30, 62, 126};

    ibr_bitrate ibr_bitrate_i (
        .clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .wait_mode_i(wait_m),
        .stop_mode_i(stop_m), .tx_bit_i(tx_bit), .rx_addr_i(rx_addr), .rx_addr_vld_i(rx_vld),
        .addr_match_o(match), .sda_shift_o(shift), .timing_o(timing), .scl_i(scl),
        .scl_o(scl_out), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe));

    ibr_bus_party ibr_bus_party_i (.clk_i(clk), .rstn_i(rstn), .scl_oe_i(scl_oe),
        .sda_oe_i(sda_oe), .stretch_i(stretch), .scl_o(scl), .sda_o(sda));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask : rchk

    task automatic pulse(input logic [6:0] a, input logic exp);
        rx_addr <= a;
        rx_vld  <= 1'b1;
        @(posedge clk);
        rx_vld <= 1'b0;
        #1 chk({31'h0, match}, {31'h0, exp});
        @(posedge clk);
    endtask : pulse

    // Cycles from the previous SCL pull-down start to the next one
    task automatic wait_rise();
        n = 0;
        do begin @(posedge clk); n++; end while (scl_oe !== 1'b0);
        do begin @(posedge clk); n++; end while (scl_oe !== 1'b1);
    endtask : wait_rise

    task automatic quiet(input int c);
        logic seen;
        seen = 1'b0;
        repeat (c) begin @(posedge clk); seen = seen | scl_oe | sda_oe; end
        chk({31'h0, seen}, 32'h0);
    endtask : quiet

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        {rstn, hsel, hwrite, wait_m, stop_m, tx_bit, rx_vld} = '0;
        {haddr, hwdata, htrans, rx_addr, stretch, n_mismatch, n_compared} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rchk(6'(i), 32'h0);
        rchk(IDX_SCL_DIV, 32'h14);
        rchk(IDX_SDA_HOLD, 32'h7);
        rchk(IDX_SS_HOLD, 32'h000B_0006);
        $display("test reset done, mismatches %0d", n_mismatch);
        xfer(1'b1, IDX_OWN_ADDR, 8'hFF);
        rchk(IDX_OWN_ADDR, 32'hFE);
        for (int i = 0; i < 5; i++) xfer(1'b1, 6'(i), 8'(8'hA5 + i));
        for (int i = 0; i < 5; i++) begin
            rchk(6'(i), 32'(8'(8'hA5 + i) & (i == 0 ? 8'hFE : 8'hFF)));
        end
        xfer(1'b1, 6'h3F, 8'hFF);
        rchk(6'h3F, 32'h0);
        $display("test registers done, mismatches %0d", n_mismatch);
        for (int i = 0; i < 8; i++) begin
            int mul, sp, t, e;
            mul = 1 << (i % 3);
            sp = 1 << i;
            t = (sct[7 - i] - 1) * sp;
            e = mul * 2 * (ft[i] + t + 2);
            xfer(1'b1, IDX_RATE_DIV, {2'(i % 3), 3'(i), 3'(7 - i)});
            xfer(1'b1, IDX_SCL_DIV, 8'h00);
            rchk(IDX_SCL_DIV, 32'(e));
            chk(32'(timing.scl_div), 32'(e));
            rchk(IDX_SDA_HOLD, 32'(mul * (ft[i] + (sdt[7 - i] - 1) * sp + 3)));
            rchk(IDX_SS_HOLD, {16'(mul * (spo[i] + t)), 16'(mul * (sto[i] + t))});
        end
        $display("test rate decode done, mismatches %0d", n_mismatch);
        xfer(1'b1, IDX_OWN_ADDR, 8'h54);
        pulse(7'h2A, 1'b1);
        pulse(7'h2B, 1'b0);
        stop_m <= 1'b1;
        pulse(7'h2A, 1'b0);
        rchk(IDX_OWN_ADDR, 32'h54);
        stop_m <= 1'b0;
        $display("test address match done, mismatches %0d", n_mismatch);
        xfer(1'b1, IDX_RATE_DIV, 8'h00);
        xfer(1'b1, IDX_GEN_CTRL, 8'h01);
        wait_rise();
        wait_rise();
        chk(32'(n), 32'h14);
        n = 0;
        do begin @(posedge clk); n++; end while (shift !== 1'b1);
        chk(32'(n), 32'h7);
        @(posedge clk);
        chk({31'h0, sda_oe}, 32'h1);
        tx_bit <= 1'b1;
        do @(posedge clk); while (shift !== 1'b1);
        @(posedge clk);
        chk({31'h0, sda_oe}, 32'h0);
        stretch <= 8'h0F;
        wait_rise();
        wait_rise();
        chk(32'(n > 20), 32'h1);
        stretch <= 8'h00;
        wait_m <= 1'b1;
        xfer(1'b1, IDX_GEN_CTRL, 8'h03);
        repeat (2) @(posedge clk);
        quiet(40);
        xfer(1'b1, IDX_GEN_CTRL, 8'h01);
        wait_rise();
        wait_rise();
        chk(32'(n), 32'h14);
        stop_m <= 1'b1;
        repeat (2) @(posedge clk);
        quiet(40);
        rchk(IDX_GEN_CTRL, 32'h01);
        stop_m <= 1'b0;
        $display("test generator done, mismatches %0d", n_mismatch);
        complete_run();
    end
endmodule : ibr_bitrate_tb

// file: sim/ibr_bus_party.sv
// Other open-drain parties on SCL and SDA, with clock stretching
`timescale 1ns/1ps
module ibr_bus_party (
    input  wire logic       clk_i,     // Bus clock
    input  wire logic       rstn_i,    // Reset, active low
    input  wire logic       scl_oe_i,  // Block pulls SCL low
    input  wire logic       sda_oe_i,  // Block pulls SDA low
    input  wire logic [7:0] stretch_i, // Cycles SCL is held low after each fall
    output logic            scl_o,     // Resolved SCL level
    output logic            sda_o      // Resolved SDA level
);
    logic [7:0] hold_q;
    logic       scl_q;

    // Pull-ups win unless some party pulls low
    assign scl_o = !(scl_oe_i || hold_q != 8'h00);
    assign sda_o = !sda_oe_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_q <= 8'h00;
            scl_q  <= 1'b1;
        end else begin
            scl_q <= scl_o;
            if (scl_q && !scl_o) begin
                hold_q <= stretch_i;
            end else if (hold_q != 8'h00) begin
                hold_q <= hold_q - 8'h01;
            end
        end
    end
endmodule : ibr_bus_party
